// [rtl/wdc_pkg.sv]
// Package: register map, field layout and timing constants of the watchdog control
// Functional notes
// RQ1: A time-out with interrupt enabled sets the interrupt flag, bit 7.
// RQ2: Executing the watchdog vector clears the interrupt flag automatically.
// RQ3: Writing one to the flag clears it; writing zero leaves it alone.
// RQ4: Interrupt requested only when flag, interrupt enable and global enable are set.
// RQ5: Reset-enable and interrupt-enable pick stopped, interrupt, reset or interrupt-then-reset.
// RQ6: In combined mode the vector clears enable and flag, leaving reset mode.
// RQ7: In combined mode an unserviced flag at the next time-out causes reset.
// RQ8: Software re-arms interrupt enable after each interrupt, preferably outside the handler.
// RQ9: Programmed always-on fuse forces reset mode whatever the enable bits say.
// RQ10: Clearing reset-enable or changing time-out select needs change-enable set.
// RQ11: Change-enable clears itself four clock cycles after being written one.
// RQ12: Reset-enable reads set while reset-cause flag is set; clear it first.
// RQ13: Time-out select is bit 5 on top of bits 2 to 0.
// RQ14: Select codes 0 to 9 give 2048 doubling to 1048576 oscillator cycles.
// RQ15: Software writes change-enable with reset-enable, then new values within four cycles.
// RQ16: Counter counts oscillator cycles and restarts on the watchdog-reset instruction.
// RQ17: Programmed fuse holds reset-enable at one and interrupt enable at zero.
// RQ18: Time-out fires at the selected count, synchronised into the core clock.
package wdc_pkg;

  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CSR_OFFSET  = 4'h0;
  localparam logic [7:0]  CSR_RST     = 8'h00;
  localparam logic [3:0]  SEL_RST     = 4'h0;
  localparam logic [3:0]  SEL_MAX     = 4'h9;
  localparam logic [2:0]  CE_CYCLES   = 3'h4;
  localparam int          TO_BASE_OSC = 2048;
  localparam int          CNT_W       = 21;

  // Control and status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       irq_flag;
    logic       irq_en;
    logic       sel_hi;
    logic       chg_en;
    logic       rst_en;
    logic [2:0] sel_lo;
  } wdc_csr_t;

  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_IRQ,
    MODE_RST,
    MODE_IRQ_RST
  } wdc_mode_t;

endpackage : wdc_pkg

// [rtl/wdc_counter.sv]
// Oscillator synchroniser and time-out counter of the watchdog
`timescale 1ns/10ps
module wdc_counter #(
  parameter int TO_BASE = wdc_pkg::TO_BASE_OSC
) (
  input  wire logic       core_clk,   // Core clock
  input  wire logic       rst_n,      // Synchronised reset
  input  wire logic       osc_in,     // Raw watchdog oscillator
  input  wire logic       run,        // Counter enabled
  input  wire logic       restart,    // Restart from zero
  input  wire logic [3:0] sel,        // Time-out select
  output logic            timeout     // One-cycle time-out pulse
);

  logic                      osc_s1_q, osc_s2_q, osc_s3_q;
  logic                      tick;
  logic [wdc_pkg::CNT_W-1:0] cnt_q, cnt_d, limit;
  logic [3:0]                sel_eff;
  logic                      timeout_q, timeout_d;

  always_comb begin
    tick = osc_s2_q & ~osc_s3_q;
    // Reserved codes act as the longest time-out
    sel_eff = (sel > wdc_pkg::SEL_MAX) ? wdc_pkg::SEL_MAX : sel; // RQ14
    limit = wdc_pkg::CNT_W'(TO_BASE) << sel_eff; // RQ14
    cnt_d = cnt_q;
    timeout_d = 1'b0;
    if (restart || !run) begin
      cnt_d = '0; // RQ16
    end else if (tick) begin
      if (cnt_q >= limit - wdc_pkg::CNT_W'(1)) begin
        cnt_d = '0;
        timeout_d = 1'b1; // RQ18
      end else begin
        cnt_d = cnt_q + wdc_pkg::CNT_W'(1); // RQ16
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      osc_s3_q  <= 1'b0;
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else begin
      osc_s1_q  <= osc_in; // RQ18
      osc_s2_q  <= osc_s1_q;
      osc_s3_q  <= osc_s2_q;
      cnt_q     <= cnt_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout = timeout_q;

endmodule : wdc_counter

// [rtl/wdc_top.sv]
// Watchdog control: register, mode decode, interrupt flag and reset request
`timescale 1ns/10ps
module wdc_top #(
  parameter int TO_BASE = wdc_pkg::TO_BASE_OSC
) (
  input  wire logic                       core_clk,        // 20 MHz core clock
  input  wire logic                       arst_n,          // Async reset, active low
  input  wire logic [wdc_pkg::ADDR_W-1:0] reg_addr,        // Register address
  input  wire logic [7:0]                 reg_wdata,       // Write data
  input  wire logic                       reg_we,          // Write strobe
  input  wire logic                       reg_re,          // Read strobe
  output logic      [7:0]                 reg_rdata,       // Read data, cycle after strobe
  input  wire logic                       osc_clk_in,      // Watchdog oscillator pin
  input  wire logic                       always_on_fuse,  // Fuse, 0 is programmed
  input  wire logic                       wdt_reset_cause, // Watchdog reset-cause flag
  input  wire logic                       global_irq_en,   // Global interrupt enable
  input  wire logic                       wdr_exec,        // Watchdog-reset instruction
  input  wire logic                       vector_ack,      // Watchdog vector executed
  output logic                            irq_req,         // Time-out interrupt request
  output logic                            sys_reset_req    // System reset pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and fuse synchroniser

  logic rst_s1_q, rst_n;
  logic fuse_s1_q, fuse_s2_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fuse_s1_q <= 1'b1;
      fuse_s2_q <= 1'b1;
    end else begin
      fuse_s1_q <= always_on_fuse;
      fuse_s2_q <= fuse_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter

  logic       timeout_evt;
  logic       run, restart;
  logic [3:0] sel_q, sel_d;

  wdc_counter #(
    .TO_BASE (TO_BASE)
  ) u_counter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .osc_in   (osc_clk_in),
    .run      (run),
    .restart  (restart),
    .sel      (sel_q),
    .timeout  (timeout_evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and mode logic

  wdc_pkg::wdc_csr_t  csr_w, csr_r;
  wdc_pkg::wdc_mode_t mode;
  logic       fuse_prog, wr, rd, wdce;
  logic       wde_eff, ie_eff, set_flag, rst_fire;
  logic       flag_q, flag_d, irq_en_q, irq_en_d, wde_q, wde_d;
  logic [2:0] ce_cnt_q, ce_cnt_d;
  logic       irq_q, irq_d, sysrst_q, sysrst_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    csr_w     = wdc_pkg::wdc_csr_t'(reg_wdata);
    wr        = reg_we && (reg_addr == wdc_pkg::CSR_OFFSET);
    rd        = reg_re && (reg_addr == wdc_pkg::CSR_OFFSET);
    fuse_prog = ~fuse_s2_q;
    wdce      = (ce_cnt_q != 3'h0);
    wde_eff   = wde_q | wdt_reset_cause | fuse_prog; // RQ12
    ie_eff    = irq_en_q & ~fuse_prog; // RQ17
    mode      = fuse_prog ? wdc_pkg::MODE_RST : wdc_pkg::wdc_mode_t'({wde_eff, ie_eff}); // RQ9
    run       = (mode != wdc_pkg::MODE_STOP); // RQ5
    restart   = wdr_exec; // RQ16
    set_flag  = 1'b0;
    rst_fire  = 1'b0;
    if (timeout_evt) begin
      case (mode)
        wdc_pkg::MODE_IRQ:     set_flag = 1'b1; // RQ5
        wdc_pkg::MODE_RST:     rst_fire = 1'b1; // RQ5
        wdc_pkg::MODE_IRQ_RST: begin
          if (flag_q) begin
            rst_fire = 1'b1; // RQ7
          end else begin
            set_flag = 1'b1; // RQ6
          end
        end
        default: ;
      endcase
    end

    // Flag: hardware set wins over both clears
    flag_d = flag_q;
    if (vector_ack) begin
      flag_d = 1'b0; // RQ2
    end
    if (wr && csr_w.irq_flag) begin
      flag_d = 1'b0; // RQ3
    end
    if (set_flag) begin
      flag_d = 1'b1; // RQ1
    end

    irq_en_d = irq_en_q;
    if (wr) begin
      irq_en_d = csr_w.irq_en;
    end
    if (vector_ack && mode == wdc_pkg::MODE_IRQ_RST) begin
      irq_en_d = 1'b0; // RQ6
    end
    if (fuse_prog) begin
      irq_en_d = 1'b0; // RQ17
    end

    // Setting reset-enable is always allowed, clearing needs the open window
    wde_d = wde_q;
    if (wr) begin
      if (csr_w.rst_en) begin
        wde_d = 1'b1;
      end else if (wdce && !wdt_reset_cause) begin
        wde_d = 1'b0; // RQ10 RQ12
      end
    end
    if (wdt_reset_cause || fuse_prog) begin
      wde_d = 1'b1; // RQ12 RQ17
    end

    sel_d = sel_q;
    if (wr && wdce) begin
      sel_d = {csr_w.sel_hi, csr_w.sel_lo}; // RQ10 RQ13
    end

    ce_cnt_d = ce_cnt_q;
    if (wr) begin
      ce_cnt_d = csr_w.chg_en ? wdc_pkg::CE_CYCLES : 3'h0;
    end else if (wdce) begin
      ce_cnt_d = ce_cnt_q - 3'h1; // RQ11
    end

    irq_d    = flag_q & ie_eff & global_irq_en; // RQ4
    sysrst_d = rst_fire;

    csr_r.irq_flag = flag_q;
    csr_r.irq_en   = irq_en_q;
    csr_r.sel_hi   = sel_q[3];
    csr_r.chg_en   = wdce;
    csr_r.rst_en   = wde_eff; // RQ12
    csr_r.sel_lo   = sel_q[2:0];
    rdata_d        = rd ? csr_r : 8'h00;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q   <= wdc_pkg::CSR_RST[7];
      irq_en_q <= wdc_pkg::CSR_RST[6];
      wde_q    <= wdc_pkg::CSR_RST[3];
      sel_q    <= wdc_pkg::SEL_RST;
      ce_cnt_q <= 3'h0;
      irq_q    <= 1'b0;
      sysrst_q <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      flag_q   <= flag_d;
      irq_en_q <= irq_en_d;
      wde_q    <= wde_d;
      sel_q    <= sel_d;
      ce_cnt_q <= ce_cnt_d;
      irq_q    <= irq_d;
      sysrst_q <= sysrst_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign irq_req       = irq_q;
  assign sys_reset_req = sysrst_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_flag_set;
    timeout_evt && mode == wdc_pkg::MODE_IRQ |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on time-out"); // RQ1

  property p_vec_clear;
    vector_ack && !set_flag |=> !flag_q;
  endproperty
  a_vec_clear: assert property (p_vec_clear) else $error("vector did not clear flag"); // RQ2

  property p_w0_keep;
    wr && !csr_w.irq_flag && !vector_ack && flag_q |=> flag_q;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("zero write changed flag"); // RQ3

  property p_irq_cause;
    irq_req |-> $past(flag_q && irq_en_q && global_irq_en);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause"); // RQ4

  property p_rst_mode;
    timeout_evt && mode == wdc_pkg::MODE_RST |=> sys_reset_req ##1 !sys_reset_req;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("no reset pulse"); // RQ5

  property p_combo_vec;
    vector_ack && mode == wdc_pkg::MODE_IRQ_RST && !wr |=> !irq_en_q && wde_eff;
  endproperty
  a_combo_vec: assert property (p_combo_vec) else $error("combined vector wrong"); // RQ6

  property p_combo_rst;
    timeout_evt && mode == wdc_pkg::MODE_IRQ_RST && flag_q |=> sys_reset_req;
  endproperty
  a_combo_rst: assert property (p_combo_rst) else $error("unserviced flag no reset"); // RQ7

  property p_fuse_rst;
    timeout_evt && fuse_prog |=> sys_reset_req && !flag_q;
  endproperty
  a_fuse_rst: assert property (p_fuse_rst) else $error("fuse did not force reset"); // RQ9

  property p_sel_locked;
    wr && !wdce |=> sel_q == $past(sel_q);
  endproperty
  a_sel_locked: assert property (p_sel_locked) else $error("select changed while locked"); // RQ10

  property p_ce_expire;
    wr && csr_w.chg_en ##1 (!wr)[*4] |=> !wdce;
  endproperty
  a_ce_expire: assert property (p_ce_expire) else $error("change enable did not expire"); // RQ11

  property p_cause_wde;
    rd && wdt_reset_cause |=> reg_rdata[3];
  endproperty
  a_cause_wde: assert property (p_cause_wde) else $error("reset enable not read set"); // RQ12

  property p_fuse_hold;
    fuse_prog ##1 fuse_prog |-> wde_q && !irq_en_q;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("fuse hold failed"); // RQ17

  property p_stop_quiet;
    mode == wdc_pkg::MODE_STOP |=> !timeout_evt;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("time-out while stopped"); // RQ5

  property p_sel_wr;
    wr && wdce |=> sel_q == {$past(csr_w.sel_hi), $past(csr_w.sel_lo)};
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select not taken in window"); // RQ13

  property p_ce_open;
    wr && csr_w.chg_en |=> wdce;
  endproperty
  a_ce_open: assert property (p_ce_open) else $error("change enable did not open"); // RQ11

  property p_wde_lock;
    wr && !wdce && wde_q |=> wde_q;
  endproperty
  a_wde_lock: assert property (p_wde_lock) else $error("reset enable cleared while locked"); // RQ10

  property p_cause_hold;
    wdt_reset_cause |=> wde_q;
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("reset enable not held by cause"); // RQ12

  property p_to_pulse;
    timeout_evt |=> !timeout_evt;
  endproperty
  a_to_pulse: assert property (p_to_pulse) else $error("time-out longer than one cycle"); // RQ18

  property p_kick_quiet;
    restart |=> !timeout_evt;
  endproperty
  a_kick_quiet: assert property (p_kick_quiet) else $error("time-out right after restart"); // RQ16

  c_irq:     cover property (timeout_evt && mode == wdc_pkg::MODE_IRQ ##1 flag_q);
  c_combo:   cover property (flag_q && timeout_evt && mode == wdc_pkg::MODE_IRQ_RST);
  c_wde_off: cover property (wr && wdce && !csr_w.rst_en ##1 !wde_q);
  c_sel_chg: cover property (wr && wdce ##1 sel_q != $past(sel_q));
  c_fuse:    cover property (fuse_prog && timeout_evt ##1 sys_reset_req);

endmodule : wdc_top

// [dv/wdc_core_model.sv]
// Core-side model: vector execution and reset request counting
`timescale 1ns/10ps
module wdc_core_model (
  input  wire logic       core_clk,      // Core clock
  input  wire logic       serve,         // Take the interrupt when requested
  input  wire logic [7:0] dly,           // Cycles before the vector runs
  input  wire logic       irq_req,       // Interrupt request
  input  wire logic       sys_reset_req, // Reset request pulse
  output logic            vector_ack,    // Vector executed
  output int              reset_cnt      // Reset requests seen
);
  int   hold  = 0;
  int   w     = 0;
  int   cnt   = 0;
  logic ack_q = 1'b0;
  assign vector_ack = ack_q;
  assign reset_cnt  = cnt;
  always @(posedge core_clk) begin
    ack_q <= 1'b0;
    if (sys_reset_req === 1'b1) cnt <= cnt + 1;
    // Hold off until the request has had time to drop
    if (hold != 0) hold <= hold - 1;
    else if (serve && irq_req === 1'b1) begin
      if (w < dly) w <= w + 1;
      else begin
        ack_q <= 1'b1;
        w <= 0;
        hold <= 3;
      end
    end
  end
endmodule : wdc_core_model

// [dv/tb_top.sv]
// Self-checking bench for the watchdog control block
`timescale 1ns/10ps
module tb_top;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, dly;
  logic       core_clk, arst_n, reg_we, reg_re, osc_clk_in, always_on_fuse, serve;
  logic       wdt_reset_cause, global_irq_en, wdr_exec, vector_ack, irq_req, sys_reset_req;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         reset_cnt, n, r0;

  wdc_top #(.TO_BASE(4)) u_wdc_top (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .osc_clk_in, .always_on_fuse, .wdt_reset_cause, .global_irq_en,
    .wdr_exec, .vector_ack, .irq_req, .sys_reset_req);
  wdc_core_model u_wdc_core_model (.core_clk, .serve, .dly, .irq_req, .sys_reset_req,
    .vector_ack, .reset_cnt);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Oscillator at 10 core cycles a period, edges on the falling core edges
  initial begin
    osc_clk_in = 1'b0;
    forever #250 osc_clk_in = ~osc_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task results;
    $display("errors=%0d tests=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task kick;
    @(posedge core_clk) wdr_exec <= 1'b1;
    @(posedge core_clk) wdr_exec <= 1'b0;
  endtask : kick

  // Timed unlock, then the new setting
  task cfg(input logic [7:0] d);
    wr(4'h0, 8'h18);
    wr(4'h0, d);
  endtask : cfg

  task idle;
    cfg(8'h00);
    wr(4'h0, 8'h80);
  endtask : idle

  task wait_irq;
    n = 0;
    while (irq_req !== 1'b1 && n < 25000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_irq

  task wait_rst;
    r0 = reset_cnt;
    n = 0;
    while (reset_cnt == r0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'(reset_cnt - r0), 8'h01);
  endtask : wait_rst

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    repeat (200) @(posedge core_clk);
    chk({7'h0, irq_req}, 8'h00);
    chk(8'(reset_cnt), 8'h00);
    rd(4'h0);
    chk(v, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5);
    chk(v, 8'h00);
    rd(4'h0);
    chk(v, 8'h00);
  endtask : t_regs

  task t_meas(input logic [3:0] s, input int lim);
    cfg({2'b01, s[3], 2'b00, s[2:0]});
    kick;
    wait_irq;
    chk({7'h0, n >= (lim - 1) * 10 - 5 && n <= lim * 10 + 15}, 8'h01);
    repeat (4) @(posedge core_clk);
    rd(4'h0);
    chk(v, {2'b01, s[3], 2'b00, s[2:0]});
  endtask : t_meas

  task t_w1c;
    serve <= 1'b0;
    @(posedge core_clk) global_irq_en <= 1'b0;
    cfg(8'h40);
    kick;
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 100) begin
      rd(4'h0);
      n++;
    end
    chk(v, 8'hc0);
    chk({7'h0, irq_req}, 8'h00);
    @(posedge core_clk) global_irq_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({7'h0, irq_req}, 8'h01);
    kick;
    wr(4'h0, 8'h40);
    rd(4'h0);
    chk(v, 8'hc0);
    wr(4'h0, 8'hc0);
    rd(4'h0);
    chk(v, 8'h40);
    idle;
  endtask : t_w1c

  task t_comb;
    serve <= 1'b1;
    dly <= 8'd20;
    wr(4'h0, 8'h48);
    kick;
    wait_irq;
    chk({7'h0, irq_req}, 8'h01);
    repeat (26) @(posedge core_clk);
    rd(4'h0);
    chk(v, 8'h08);
    wait_rst;
    // Re-arm outside the handler
    wr(4'h0, 8'h48);
    serve <= 1'b0;
    wait_irq;
    chk({7'h0, irq_req}, 8'h01);
    wait_rst;
    idle;
    serve <= 1'b1;
  endtask : t_comb

  task t_chg;
    wr(4'h0, 8'h08);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(v, 8'h08);
    wr(4'h0, 8'h18);
    rd(4'h0);
    chk(v, 8'h18);
    wr(4'h0, 8'h21);
    rd(4'h0);
    chk(v, 8'h21);
    wr(4'h0, 8'h18);
    repeat (5) @(posedge core_clk);
    wr(4'h0, 8'h00);
    rd(4'h0);
    chk(v, 8'h29);
    @(posedge core_clk) wdt_reset_cause <= 1'b1;
    idle;
    rd(4'h0);
    chk(v, 8'h08);
    @(posedge core_clk) wdt_reset_cause <= 1'b0;
    rd(4'h0);
    chk(v, 8'h08);
    idle;
    rd(4'h0);
    chk(v, 8'h00);
  endtask : t_chg

  task t_fuse;
    @(posedge core_clk) always_on_fuse <= 1'b0;
    repeat (3) @(posedge core_clk);
    wr(4'h0, 8'h40);
    rd(4'h0);
    chk(v, 8'h08);
    kick;
    wait_rst;
    @(posedge core_clk) always_on_fuse <= 1'b1;
    repeat (3) @(posedge core_clk);
    idle;
    rd(4'h0);
    chk(v, 8'h00);
  endtask : t_fuse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    always_on_fuse = 1'b1;
    wdt_reset_cause = 1'b0;
    global_irq_en = 1'b1;
    wdr_exec = 1'b0;
    serve = 1'b1;
    dly = 8'd0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs;
    t_meas(4'h0, 4);
    t_meas(4'h3, 32);
    t_meas(4'ha, 2048);
    idle;
    t_w1c;
    t_comb;
    t_chg;
    t_fuse;
    results;
  end

  initial begin
    #3000000;
    error_cnt++;
    results;
  end
endmodule : tb_top
